// >>> include/xpt_pkg.sv
// Purpose: shared constants for the external bus phase timer
// Assumes: one 250 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses, one 32-bit word per register
package xpt_pkg;
    localparam int ZONES = 3;
    localparam int LEAD_W = 2;
    localparam int ACT_W = 3;
    localparam int TRAIL_W = 2;
    localparam int CNT_W = 8;
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REQ = 8'h08;
    localparam logic [7:0] ADDR_TIMING0 = 8'h10;
    localparam logic [7:0] ADDR_DONE_CNT = 8'h20;
    // zone timing register fields
    localparam int F_RD_LEAD = 0;
    localparam int F_RD_ACT = 2;
    localparam int F_RD_TRAIL = 5;
    localparam int F_WR_LEAD = 7;
    localparam int F_WR_ACT = 9;
    localparam int F_WR_TRAIL = 12;
    localparam int F_DOUBLE = 14;
    localparam int F_USE_READY = 15;
    localparam int F_READY_STYLE = 16;
    localparam logic [16:0] TIMING_RESET = 17'h1ffff;
    // control fields
    localparam int F_CLK_HALF = 0;
    localparam int F_TIMCLK_HALF = 1;
    // request fields
    localparam int F_REQ_WRITE = 0;
    localparam int F_REQ_ZONE = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LEAD = 2'b01,
        PH_ACTIVE = 2'b10,
        PH_TRAIL = 2'b11
    } xpt_phase_e;
endpackage

// >>> src/xpt_clk_div.sv
// Purpose: divider making the timing-clock enable and the external bus clock
// Assumes: halves selected by control bits
// Notes: the bus clock toggles on timing ticks when halved
`timescale 1ns/100ps
module xpt_clk_div
    import xpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timclk_half,
    input wire logic busclk_half,
    output logic tick,
    output logic bus_clk
);
    logic phase;
    logic next_phase;
    logic next_tick;
    logic next_bus_clk;
    logic half_phase;
    logic next_half_phase;

    // full rate at full timing is capped at half of aclk, a flop toggles once a cycle
    always_comb begin
        next_phase = timclk_half ? ~phase : 1'b1;
        next_tick = timclk_half ? phase : 1'b1;
        next_bus_clk = bus_clk;
        next_half_phase = half_phase;
        if (next_tick) begin
            next_half_phase = ~half_phase;
            if (!busclk_half || timclk_half || half_phase) begin
                next_bus_clk = ~bus_clk;
            end
        end
        if (!busclk_half && !next_tick) begin
            next_bus_clk = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 1'b0;
            tick <= 1'b0;
            bus_clk <= 1'b0;
            half_phase <= 1'b0;
        end else begin
            phase <= next_phase;
            tick <= next_tick;
            bus_clk <= next_bus_clk;
            half_phase <= next_half_phase;
        end
    end
endmodule

// >>> src/xpt_ready_sync.sv
// Purpose: ready input sampling, direct or through two flops
// Assumes: ready is high when the external device is ready
// Notes: async style adds two cycles of latency
`timescale 1ns/100ps
module xpt_ready_sync
    import xpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ready_in,
    input wire logic async_style,
    output logic ready_ok
);
    logic meta;
    logic sync;
    logic next_ready_ok;

    always_comb begin
        next_ready_ok = async_style ? sync : ready_in;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            ready_ok <= 1'b0;
        end else begin
            meta <= ready_in;
            sync <= meta;
            ready_ok <= next_ready_ok;
        end
    end
endmodule

// >>> src/xpt_phase_timer.sv
// Purpose: lead/active/trail phase timer for external parallel memory zones
// Assumes: AXI4-Lite slave, answers one cycle after both write channels are taken
// Notes: timing values are never checked; software keeps them legal
`timescale 1ns/100ps
module xpt_phase_timer
    import xpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_ready_input,
    output logic read_strobe_n,
    output logic write_strobe_low_n,
    output logic write_strobe_high_n,
    output logic [ZONES-1:0] zone_chip_select_n,
    output logic external_bus_clock_output
);
    // ******************************
    // registers
    // ******************************
    logic [16:0] zone_timing_register [ZONES];
    logic [16:0] next_timing [ZONES];
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [31:0] done_cnt;
    logic [31:0] next_done_cnt;
    logic aw_hold;
    logic next_aw_hold;
    logic w_hold;
    logic next_w_hold;
    logic [7:0] aw_addr;
    logic [7:0] next_aw_addr;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic req_pulse;
    logic req_write;
    logic [1:0] req_zone;

    // ******************************
    // phase state
    // ******************************
    xpt_phase_e phase;
    xpt_phase_e next_phase;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic is_write;
    logic next_is_write;
    logic [1:0] zone;
    logic [1:0] next_zone;
    logic pend;
    logic next_pend;
    logic pend_write;
    logic next_pend_write;
    logic [1:0] pend_zone;
    logic [1:0] next_pend_zone;
    logic tick;
    logic bus_clk;
    logic ready_ok;
    logic next_rd_n;
    logic next_wr_n;
    logic [ZONES-1:0] next_cs_n;

    // count doubling for the phase sequencer and register word widening for the read path
    function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] v, input logic dbl);
        scale = dbl ? CNT_W'(v << 1) : v;
    endfunction

    function automatic logic [31:0] reg_word(input logic [16:0] v);
        reg_word = 32'(v);
    endfunction

    logic [16:0] cur;
    assign cur = zone_timing_register[zone];

    xpt_clk_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .timclk_half(ctrl[F_TIMCLK_HALF]),
        .busclk_half(ctrl[F_CLK_HALF]),
        .tick(tick),
        .bus_clk(bus_clk)
    );

    xpt_ready_sync u_rdy (
        .aclk(aclk),
        .aresetn(aresetn),
        .ready_in(external_ready_input),
        .async_style(cur[F_READY_STYLE]),
        .ready_ok(ready_ok)
    );

    // ******************************
    // bus slave
    // ******************************
    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_ctrl = ctrl;
        for (int i = 0; i < ZONES; i++) begin
            next_timing[i] = zone_timing_register[i];
        end
        req_pulse = 1'b0;
        req_write = 1'b0;
        req_zone = 2'b00;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_hold && w_hold && !s_axi_bvalid) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (aw_addr >= ADDR_TIMING0 && aw_addr < ADDR_TIMING0 + 8'(4 * ZONES)) begin
                for (int i = 0; i < ZONES; i++) begin
                    if (aw_addr == ADDR_TIMING0 + 8'(4 * i)) begin
                        if (w_strb[0]) next_timing[i][7:0] = w_data[7:0];
                        if (w_strb[1]) next_timing[i][15:8] = w_data[15:8];
                        if (w_strb[2]) next_timing[i][16] = w_data[16];
                    end
                end
            end else if (aw_addr == ADDR_CTRL) begin
                if (w_strb[0]) next_ctrl = w_data[1:0];
            end else if (aw_addr == ADDR_REQ) begin
                req_pulse = 1'b1;
                req_write = w_data[F_REQ_WRITE];
                req_zone = w_data[F_REQ_ZONE +: 2];
                if (w_data[F_REQ_ZONE +: 2] >= 2'(ZONES)) next_bresp = RESP_SLVERR;
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            if (s_axi_araddr == ADDR_CTRL) begin
                next_rdata = 32'(ctrl);
            end else if (s_axi_araddr == ADDR_STATUS) begin
                next_rdata = {27'h0, pend, is_write, phase, ready_ok};
            end else if (s_axi_araddr == ADDR_DONE_CNT) begin
                next_rdata = done_cnt;
            end else if (s_axi_araddr >= ADDR_TIMING0
                         && s_axi_araddr < ADDR_TIMING0 + 8'(4 * ZONES)) begin
                next_rdata = reg_word(zone_timing_register[2'(s_axi_araddr[3:2])]);
            end else if (s_axi_araddr != ADDR_REQ) begin
                next_rresp = RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // ******************************
    // phase sequencer
    // ******************************
    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        next_is_write = is_write;
        next_zone = zone;
        next_pend = pend;
        next_pend_write = pend_write;
        next_pend_zone = pend_zone;
        next_done_cnt = done_cnt;
        next_rd_n = read_strobe_n;
        next_wr_n = write_strobe_low_n;
        next_cs_n = zone_chip_select_n;
        if (req_pulse && req_zone < 2'(ZONES)) begin
            next_pend = 1'b1;
            next_pend_write = req_write;
            next_pend_zone = req_zone;
        end
        if (tick) begin
            unique case (phase)
                PH_IDLE: begin
                    if (pend) begin
                        // start lead phase
                        // a refused zone must not leave a request queued
                        next_pend = req_pulse && req_zone < 2'(ZONES);
                        next_is_write = pend_write;
                        next_zone = pend_zone;
                        next_phase = PH_LEAD;
                        next_cs_n = ~(ZONES'(1) << pend_zone);
                        next_cnt = scale(CNT_W'(pend_write
                            ? zone_timing_register[pend_zone][F_WR_LEAD +: LEAD_W]
                            : zone_timing_register[pend_zone][F_RD_LEAD +: LEAD_W]),
                            zone_timing_register[pend_zone][F_DOUBLE]);
                    end
                end
                PH_LEAD: begin
                    if (cnt <= CNT_W'(1)) begin
                        next_phase = PH_ACTIVE;
                        next_cnt = scale(CNT_W'(is_write ? cur[F_WR_ACT +: ACT_W]
                            : cur[F_RD_ACT +: ACT_W]), cur[F_DOUBLE]) + CNT_W'(1);
                        next_rd_n = is_write;
                        next_wr_n = ~is_write;
                    end else begin
                        next_cnt = cnt - CNT_W'(1);
                    end
                end
                PH_ACTIVE: begin
                    if (cnt <= CNT_W'(1) && (!cur[F_USE_READY] || ready_ok)) begin
                        next_phase = PH_TRAIL;
                        next_rd_n = 1'b1;
                        next_wr_n = 1'b1;
                        next_cnt = scale(CNT_W'(is_write ? cur[F_WR_TRAIL +: TRAIL_W]
                            : cur[F_RD_TRAIL +: TRAIL_W]), cur[F_DOUBLE]);
                    end else if (cnt > CNT_W'(1)) begin
                        next_cnt = cnt - CNT_W'(1);
                    end
                end
                PH_TRAIL: begin
                    if (cnt <= CNT_W'(1)) begin
                        next_phase = PH_IDLE;
                        next_cs_n = '1;
                        next_done_cnt = done_cnt + 32'h1;
                    end else begin
                        next_cnt = cnt - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < ZONES; i++) begin
                zone_timing_register[i] <= TIMING_RESET;
            end
            ctrl <= 2'h0;
            done_cnt <= 32'h0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            phase <= PH_IDLE;
            cnt <= '0;
            is_write <= 1'b0;
            zone <= 2'h0;
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_zone <= 2'h0;
            read_strobe_n <= 1'b1;
            write_strobe_low_n <= 1'b1;
            write_strobe_high_n <= 1'b1;
            zone_chip_select_n <= '1;
            external_bus_clock_output <= 1'b0;
        end else begin
            for (int i = 0; i < ZONES; i++) begin
                zone_timing_register[i] <= next_timing[i];
            end
            ctrl <= next_ctrl;
            done_cnt <= next_done_cnt;
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_awready <= ~next_aw_hold & ~next_bvalid;
            s_axi_wready <= ~next_w_hold & ~next_bvalid;
            s_axi_arready <= ~next_rvalid & ~(s_axi_arvalid & s_axi_arready);
            phase <= next_phase;
            cnt <= next_cnt;
            is_write <= next_is_write;
            zone <= next_zone;
            pend <= next_pend;
            pend_write <= next_pend_write;
            pend_zone <= next_pend_zone;
            read_strobe_n <= next_rd_n;
            write_strobe_low_n <= next_wr_n;
            write_strobe_high_n <= next_wr_n;
            zone_chip_select_n <= next_cs_n;
            external_bus_clock_output <= bus_clk;
        end
    end

    // ******************************
    // checks
    // ******************************
    strobe_in_active_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (!read_strobe_n || !write_strobe_low_n) |-> phase == PH_ACTIVE)
        else $error("strobe outside active phase");
    cs_during_access_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (phase != PH_IDLE) |-> !(&zone_chip_select_n))
        else $error("chip select released during access");
    outputs_on_tick_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            $changed(zone_chip_select_n) |-> $past(tick))
        else $error("chip select moved off a tick");
    no_wait_ignored_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (phase == PH_ACTIVE && tick && cnt == CNT_W'(1) && !cur[F_USE_READY])
            |=> phase == PH_TRAIL)
        else $error("wait inserted while ready ignored");
    wait_ready_low_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (phase == PH_ACTIVE && cur[F_USE_READY] && !ready_ok) |=> phase == PH_ACTIVE)
        else $error("active ended while not ready");
    lead_counts_down_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (phase == PH_LEAD && tick && cnt > CNT_W'(1)) |=> phase == PH_LEAD
                && cnt == $past(cnt) - CNT_W'(1))
        else $error("lead count not decremented");
    trail_to_idle_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (phase == PH_TRAIL && tick && cnt <= CNT_W'(1)) |=> phase == PH_IDLE
                && done_cnt == $past(done_cnt) + 32'h1)
        else $error("trail did not close access");
    resp_held_a:
        assert property (@(posedge aclk) disable iff (!aresetn)
            (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule

// >>> testbench/xpt_mem_model.sv
// Purpose: external memory partner that drives the ready line
// Assumes: ready is held low for wait_cycles strobe cycles of an access
// Notes: ready toggles while no zone is selected, the line has no pull
`timescale 1ns/100ps
module xpt_mem_model
    import xpt_pkg::*;
(
    input wire logic aclk,
    input wire logic [ZONES-1:0] zone_chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_low_n,
    input wire logic [3:0] wait_cycles,
    output logic external_ready_input
);
    // ********
    // ready answer
    // ********
    logic [3:0] held = 4'h0;
    logic flip = 1'b0;
    always @(posedge aclk) begin
        flip <= ~flip;
        if (&zone_chip_select_n) begin
            held <= 4'h0;
        end else if (!(read_strobe_n && write_strobe_low_n) && held != 4'hf) begin
            held <= held + 4'h1;
        end
    end
    assign external_ready_input = (&zone_chip_select_n) ? flip : (held >= wait_cycles);
endmodule

// >>> testbench/test_ext_bus_access_phase_timer.sv
// Purpose: self-checking bench for the phase timer
// Assumes: one timing tick per clock unless the control register halves it
// Notes: phase lengths are measured at the select and strobe pins
`timescale 1ns/100ps
module test_ext_bus_access_phase_timer
    import xpt_pkg::*;
;
    `define CHK(n, e, g) begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("[FAIL] %s expected %0h seen %0h", n, e, g); \
        end \
    end
    typedef struct {
        int zone;
        int wr;
        int lead;
        int alo;
        int ahi;
        int trail;
    } xpt_note_s;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, wait_cycles;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [ZONES-1:0] zone_chip_select_n;
    logic external_ready_input, read_strobe_n, write_strobe_low_n, write_strobe_high_n;
    logic external_bus_clock_output, kw;
    int errors = 0;
    int comparisons = 0;
    int seed, ln, an, tn, zq, nacc;
    int per = 1;
    xpt_note_s aq[$];
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    xpt_phase_timer dut (.*);
    xpt_mem_model partner (.*);
    always #2 aclk = ~aclk;
    // ********
    // checks
    // ********
    always @(posedge aclk) begin
        xpt_note_s e;
        logic [33:0] r;
        logic [1:0] b;
        if (s_axi_bvalid && s_axi_bready) begin
            b = bq.pop_front();
            `CHK("bresp", b, s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            r = rq.pop_front();
            `CHK("rresp", r[33:32], s_axi_rresp)
            if (r[33:32] == RESP_OKAY) `CHK("rdata", r[31:0], s_axi_rdata)
        end
        if (!aresetn || &zone_chip_select_n) begin
            if (aresetn) `CHK("idle strobes", 1'b1, read_strobe_n & write_strobe_low_n)
            if (aresetn && ln + an > 0) begin
                `CHK("expected access", 1'b1, aq.size() > 0)
                e = aq.pop_front();
                `CHK("zone", e.zone, zq)
                `CHK("kind", e.wr, int'(kw))
                `CHK("lead", e.lead, ln)
                `CHK("active", 1'b1, an >= e.alo && an <= e.ahi)
                `CHK("trail", e.trail, tn)
            end
            ln = 0;
            an = 0;
            tn = 0;
        end else if (!(read_strobe_n && write_strobe_low_n)) begin
            an++;
            kw = !write_strobe_low_n;
            `CHK("strobe pair", write_strobe_low_n, write_strobe_high_n)
            `CHK("strobe after trail", 0, tn)
        end else if (an == 0) begin
            ln++;
            zq = zone_chip_select_n[0] ? (zone_chip_select_n[1] ? 2 : 1) : 0;
            `CHK("one select", 1'b1, $countones(~zone_chip_select_n) == 1)
        end else begin
            tn++;
        end
    end
    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic timeout();
        errors++;
        $display("[FAIL] wait bound expected answer seen none");
        results();
    endtask
    // ********
    // stimulus
    // ********
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 64) timeout();
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 64) timeout();
        @(posedge aclk);
    endtask
    function automatic xpt_note_s calc(logic [16:0] t, logic w, int z, int lo, int hi);
        int d, l, a, r;
        d = t[F_DOUBLE] ? 2 : 1;
        l = d * (w ? t[F_WR_LEAD +: LEAD_W] : t[F_RD_LEAD +: LEAD_W]);
        a = d * (w ? t[F_WR_ACT +: ACT_W] : t[F_RD_ACT +: ACT_W]) + 1;
        r = d * (w ? t[F_WR_TRAIL +: TRAIL_W] : t[F_RD_TRAIL +: TRAIL_W]);
        calc.zone = z;
        calc.wr = w;
        calc.lead = per * (l == 0 ? 1 : l);
        calc.alo = hi > 0 ? lo : per * a;
        calc.ahi = hi > 0 ? hi : per * a;
        calc.trail = per * (r == 0 ? 1 : r);
    endfunction
    task automatic acc(int z, logic w, logic [16:0] t, logic [3:0] wt, int lo, int hi);
        int n;
        wait_cycles <= wt;
        wr(ADDR_TIMING0 + 8'(4 * z), 32'(t), RESP_OKAY);
        rd(ADDR_TIMING0 + 8'(4 * z), 32'(t), RESP_OKAY);
        aq.push_back(calc(t, w, z, lo, hi));
        wr(ADDR_REQ, (32'(z) << F_REQ_ZONE) | 32'(w), RESP_OKAY);
        for (n = 0; n < 200 && aq.size() > 0; n++) @(posedge aclk);
        if (aq.size() > 0) timeout();
        nacc++;
    endtask
    task automatic clk_rate(input logic [31:0] ctrl, output int c);
        logic p;
        wr(ADDR_CTRL, ctrl, RESP_OKAY);
        c = 0;
        repeat (16) begin
            p = external_bus_clock_output;
            @(posedge aclk);
            c += int'(p !== external_bus_clock_output);
        end
    endtask
    initial begin
        int i, c0, c1;
        logic [16:0] t;
        seed = 32'h0f8522b1;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wait_cycles} = 52'h0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < ZONES; i++) rd(ADDR_TIMING0 + 8'(4 * i), 32'(TIMING_RESET), RESP_OKAY);
        wr(8'h3c, 32'h0, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        // a missing zone must start no access
        wr(ADDR_REQ, 32'h30, RESP_SLVERR);
        repeat (20) @(posedge aclk);
        for (i = 0; i < 12; i++) begin
            t = (17'($random(seed)) & 17'h07fff) | 17'h00081;
            acc(i % ZONES, 1'((i / ZONES) % 2), t, 4'($random(seed)), 0, 0);
        end
        acc(1, 1'b0, 17'h00000, 4'h0, 0, 0);
        acc(0, 1'b1, 17'h01326, 4'h6, 0, 0);
        acc(1, 1'b0, 17'h09326, 4'h0, 0, 0);
        acc(2, 1'b1, 17'h09326, 4'h6, 6, 10);
        acc(0, 1'b0, 17'h193a7, 4'h0, 0, 0);
        acc(1, 1'b1, 17'h193a7, 4'h6, 7, 12);
        // halved tick: every phase edge lands on a tick
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        per = 2;
        acc(2, 1'b0, 17'h01326, 4'h0, 0, 0);
        acc(0, 1'b1, 17'h05326, 4'h0, 0, 0);
        per = 1;
        clk_rate(32'h0, c0);
        clk_rate(32'h1, c1);
        `CHK("bus clock ratio", 1'b1, c0 == 2 * c1 && c1 > 0)
        rd(ADDR_DONE_CNT, 32'(nacc), RESP_OKAY);
        results();
    end
endmodule
